/* File: core/sipct_core.sv */
/*
 * Switch ingress policy and CPU tagging: per-packet forwarding decision, throttling,
 * mirroring, special tags and drop counters, with an APB register slave.
 * Assumes one descriptor per cycle at most from a parser that supplies parsed fields.
 */
`default_nettype none
module sipct_core #(
	parameter int THROT_CYC = sipct_pkg::THROT_INTERVAL_CYC,
	parameter int CNT_W = 16
) (
	input wire logic clock,
	input wire logic nrst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Packet descriptor from the parser.
	input wire logic pkt_valid,
	input wire logic [1:0] pkt_src,
	input wire logic [10:0] pkt_len,
	input wire logic pkt_bcast,
	input wire logic pkt_flood,
	input wire logic pkt_ipv4,
	input wire logic [7:0] pkt_ip_proto,
	input wire logic pkt_mcast,
	input wire logic pkt_tagged,
	input wire logic [15:0] pkt_tag1,
	input wire logic pkt_tag2_valid,
	input wire logic [11:0] pkt_vid2,
	input wire logic [2:0] pkt_class_pri,
	input wire logic [2:0] lookup_dest,
	input wire logic lookup_hit,
	input wire logic lookup_static,
	input wire logic lookup_age,
	input wire logic lookup_pri_en,
	input wire logic [2:0] lookup_pri,
	input wire logic [2:0] vlan_members,
	input wire logic [5:0] port_stp_state,
	input wire logic [7:0] bcast_buffers_used,
	input wire logic [2:0] learn_discard_evt,
	// Decision out, one cycle after pkt_valid.
	output logic dec_valid,
	output logic [2:0] dec_dest,
	output logic dec_filtered,
	output logic [2:0] dec_pri,
	output logic dec_strip_special,
	output logic dec_learn,
	output logic dec_add_special,
	output logic [15:0] dec_special_tag
);
	localparam int N = sipct_pkg::NPORTS;

	// Turns a port number into a one-hot mask; value 3 means all ports.
	function automatic logic [2:0] port_mask(input logic [1:0] p);
		port_mask = (p == 2'h3) ? 3'h7 : 3'(3'h1 << p);
	endfunction : port_mask

	// Registers.
	logic [31:0] throt_reg, throt_next;
	logic [31:0] bcap_reg, bcap_next;
	logic [31:0] glb_reg, glb_next;
	logic [31:0] mir_reg, mir_next;
	logic [5:0] intype_reg, intype_next;
	logic [5:0] egtype_reg, egtype_next;
	logic [11:0] pcfg_reg, pcfg_next;
	logic [N*CNT_W-1:0] lrn_cnt_reg, lrn_cnt_next;
	logic [N*CNT_W-1:0] flt_cnt_reg, flt_cnt_next;
	logic [31:0] tick_reg, tick_next;
	logic [N*16-1:0] bbytes_reg, bbytes_next;
	logic [31:0] prdata_reg, prdata_next;
	logic dvalid_reg, dvalid_next;
	logic [2:0] ddest_reg, ddest_next;
	logic dfilt_reg, dfilt_next;
	logic [2:0] dpri_reg, dpri_next;
	logic dstrip_reg, dstrip_next;
	logic dlearn_reg, dlearn_next;
	logic dadd_reg, dadd_next;
	logic [15:0] dtag_reg, dtag_next;

	logic wr, rd, hit;
	logic [1:0] src_type, stp;
	logic special, igmp, monitored, base_filt, throt_drop, filt, over, in_fwd;
	logic [2:0] src_mask, dest, fwd, mir_rx_ports, mir_tx_ports, sniff_mask;
	logic [1:0] src_idx;
	logic [11:0] vid;
	logic [15:0] lvl_bytes;
	logic [16:0] new_bytes;
	logic mirrored;
	logic [1:0] mon_port, sniff_port, cpu_port;

	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign prdata = prdata_reg;

	// APB decode; any unmapped address raises pslverr in the access phase.
	always_comb begin
		hit = 1'b1;
		prdata_next = prdata_reg;
		unique case (paddr)
			sipct_pkg::OFF_THROT, sipct_pkg::OFF_BCAP, sipct_pkg::OFF_GLOBAL,
			sipct_pkg::OFF_MIRROR, sipct_pkg::OFF_INTYPE, sipct_pkg::OFF_EGTYPE,
			sipct_pkg::OFF_PORTCFG: hit = 1'b1;
			default: hit = (paddr[7:4] == sipct_pkg::OFF_LRNCNT0[7:4] ||
				paddr[7:4] == sipct_pkg::OFF_FLTCNT0[7:4]) && paddr[3:2] != 2'h3
				&& paddr[1:0] == 2'h0;
		endcase
		if (rd) begin
			unique case (paddr)
				sipct_pkg::OFF_THROT: prdata_next = throt_reg;
				sipct_pkg::OFF_BCAP: prdata_next = bcap_reg;
				sipct_pkg::OFF_GLOBAL: prdata_next = glb_reg;
				sipct_pkg::OFF_MIRROR: prdata_next = mir_reg;
				sipct_pkg::OFF_INTYPE: prdata_next = {26'h0, intype_reg};
				sipct_pkg::OFF_EGTYPE: prdata_next = {26'h0, egtype_reg};
				sipct_pkg::OFF_PORTCFG: prdata_next = {20'h0, pcfg_reg};
				default: begin
					prdata_next = 32'h0;
					if (hit && paddr[7:4] == sipct_pkg::OFF_LRNCNT0[7:4])
						prdata_next = 32'(lrn_cnt_reg[paddr[3:2]*CNT_W +: CNT_W]);
					else if (hit)
						prdata_next = 32'(flt_cnt_reg[paddr[3:2]*CNT_W +: CNT_W]);
				end
			endcase
		end
	end
	assign pslverr = psel & penable & ~hit;

	// Packet classification and forwarding decision.
	always_comb begin
		src_idx = pkt_src;
		src_mask = port_mask(pkt_src);
		src_type = intype_reg[pkt_src*2 +: 2];
		special = (src_type == sipct_pkg::PTYPE_SPECIAL) & pkt_tagged;
		stp = port_stp_state[pkt_src*2 +: 2];
		over = lookup_hit & lookup_static & lookup_age;
		// Multicast IPv4 protocol 2 in any framing the parser handles.
		igmp = pkt_ipv4 & (pkt_ip_proto == sipct_pkg::IP_PROTO_IGMP) & pkt_mcast;
		monitored = glb_reg[sipct_pkg::GLB_IGMP_EN] & igmp & ~special;
		mon_port = glb_reg[sipct_pkg::GLB_MONPORT_POS +: 2];
		vid = special ? pkt_vid2 : pkt_tag1[11:0];
		in_fwd = (stp == sipct_pkg::STP_FWD);
		// Source-port state filtering.
		base_filt = (stp == sipct_pkg::STP_DISABLED) | (~in_fwd & ~over);
		// VLAN admission filtering.
		if (glb_reg[sipct_pkg::GLB_VLAN_EN] && (!special || pkt_tag1[6])) begin
			if (pcfg_reg[sipct_pkg::PC_TAGONLY_POS + src_idx] &&
				(!(special ? pkt_tag2_valid : pkt_tagged) || vid == 12'h000))
				base_filt = 1'b1;
			if ((special ? pkt_tag2_valid : pkt_tagged) && vid == sipct_pkg::VID_RESERVED)
				base_filt = 1'b1;
			if (pcfg_reg[sipct_pkg::PC_CHKMEM_POS + src_idx] &&
				!pcfg_reg[sipct_pkg::PC_NONMEM_POS + src_idx] && !vlan_members[src_idx])
				base_filt = 1'b1;
		end
		// Broadcast byte budget per interval and shared buffer cap.
		lvl_bytes = 16'(throt_reg[src_idx*8 +: 8] * sipct_pkg::BYTE_UNIT);
		new_bytes = {1'b0, bbytes_reg[src_idx*16 +: 16]} + 17'(pkt_len);
		throt_drop = (throt_reg[sipct_pkg::THROT_EN_POS + src_idx] & pkt_bcast &
			(new_bytes > {1'b0, lvl_bytes})) |
			(pkt_flood & (bcast_buffers_used >= bcap_reg[7:0]));
		dest = lookup_dest;
		if (special && !pkt_tag1[3]) begin
			dest = port_mask(pkt_tag1[1:0]);
			if (!pkt_tag1[4]) dest = dest & ~port_stp_blocked(port_stp_state);
			base_filt = 1'b0;
		end else if (special) begin
			dest = lookup_dest & (over ? 3'h7 : ~port_stp_blocked(port_stp_state));
			base_filt = 1'b0;
		end
		if (monitored) dest = port_mask(mon_port);
		filt = base_filt | throt_drop;
		fwd = filt ? 3'h0 : dest;
		// Loopback only for monitored IGMP when reflection is on.
		if (!(monitored && glb_reg[sipct_pkg::GLB_REFLECT])) fwd = fwd & ~src_mask;
		// Mirroring to the sniffer port; a sniffer value of 3 means all ports.
		mir_rx_ports = mir_reg[sipct_pkg::MIR_RXPORTS_POS +: 3];
		mir_tx_ports = mir_reg[sipct_pkg::MIR_TXPORTS_POS +: 3];
		sniff_port = mir_reg[sipct_pkg::MIR_SNIFF_POS +: 2];
		sniff_mask = port_mask(sniff_port);
		mirrored = (mir_reg[sipct_pkg::MIR_RX_EN] && (mir_rx_ports & src_mask) != 3'h0 &&
			(!filt || mir_reg[sipct_pkg::MIR_FILT_EN])) ||
			(mir_reg[sipct_pkg::MIR_TX_EN] && (mir_tx_ports & fwd) != 3'h0);
		if (mirrored) fwd = fwd | (sniff_mask & ~src_mask);
		cpu_port = mon_port;
		ddest_next = fwd;
		dvalid_next = pkt_valid;
		dfilt_next = pkt_valid & filt;
		// Priority from tag or classification.
		dpri_next = (special && !pkt_tag1[5]) ? pkt_tag1[15:13] : pkt_class_pri;
		dstrip_next = special;
		dlearn_next = special ? (pkt_tag1[3] & pcfg_reg[sipct_pkg::PC_LRN_POS + src_idx] &
			(in_fwd | stp == sipct_pkg::STP_LEARN)) :
			(pcfg_reg[sipct_pkg::PC_LRN_POS + src_idx] & (in_fwd | stp == sipct_pkg::STP_LEARN));
		// Egress special tag toward the CPU port.
		dadd_next = (egtype_reg[cpu_port*2 +: 2] == sipct_pkg::PTYPE_SPECIAL) &
			fwd[cpu_port];
		dtag_next = {dpri_next, 1'b0, 12'h000};
		dtag_next[1:0] = pkt_src;
		dtag_next[3] = monitored;
		if (lookup_hit && lookup_static) begin
			dtag_next[4] = over;
			dtag_next[5] = 1'b1;
			dtag_next[6] = lookup_pri_en;
			dtag_next[9:7] = lookup_pri;
		end
	end

	// Ports in a blocking, learning or disabled state, as a mask.
	function automatic logic [2:0] port_stp_blocked(input logic [5:0] st);
		for (int i = 0; i < 3; i++) port_stp_blocked[i] = (st[i*2 +: 2] != sipct_pkg::STP_FWD);
	endfunction : port_stp_blocked

	// Register writes, interval timer, byte budgets and counters.
	always_comb begin
		throt_next = throt_reg;
		bcap_next = bcap_reg;
		glb_next = glb_reg;
		mir_next = mir_reg;
		intype_next = intype_reg;
		egtype_next = egtype_reg;
		pcfg_next = pcfg_reg;
		if (wr) begin
			unique case (paddr)
				sipct_pkg::OFF_THROT: throt_next = pwdata;
				sipct_pkg::OFF_BCAP: bcap_next = pwdata;
				sipct_pkg::OFF_GLOBAL: glb_next = pwdata;
				sipct_pkg::OFF_MIRROR: mir_next = pwdata;
				sipct_pkg::OFF_INTYPE: intype_next = pwdata[5:0];
				sipct_pkg::OFF_EGTYPE: egtype_next = pwdata[5:0];
				sipct_pkg::OFF_PORTCFG: pcfg_next = pwdata[11:0];
				default: ;
			endcase
		end
		// A new interval resets every budget; a packet in that cycle starts the new one.
		tick_next = (tick_reg >= 32'(THROT_CYC - 1)) ? 32'h0 : tick_reg + 32'h1;
		bbytes_next = (tick_reg >= 32'(THROT_CYC - 1)) ? '0 : bbytes_reg;
		if (pkt_valid && pkt_bcast && !throt_drop)
			bbytes_next[src_idx*16 +: 16] = (tick_reg >= 32'(THROT_CYC - 1)) ?
				16'(pkt_len) : new_bytes[15:0];
		lrn_cnt_next = lrn_cnt_reg;
		flt_cnt_next = flt_cnt_reg;
		for (int i = 0; i < N; i++) begin
			if (learn_discard_evt[i])
				lrn_cnt_next[i*CNT_W +: CNT_W] = lrn_cnt_reg[i*CNT_W +: CNT_W] + 1'b1;
		end
		if (pkt_valid && filt)
			flt_cnt_next[src_idx*CNT_W +: CNT_W] =
				flt_cnt_reg[src_idx*CNT_W +: CNT_W] + 1'b1;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			throt_reg <= sipct_pkg::THROT_RESET;
			bcap_reg <= sipct_pkg::BCAP_RESET;
			glb_reg <= 32'h0;
			mir_reg <= 32'h0;
			intype_reg <= 6'h0;
			egtype_reg <= 6'h0;
			pcfg_reg <= 12'h0;
			lrn_cnt_reg <= '0;
			flt_cnt_reg <= '0;
			tick_reg <= 32'h0;
			bbytes_reg <= '0;
			prdata_reg <= 32'h0;
			dvalid_reg <= 1'b0;
			ddest_reg <= 3'h0;
			dfilt_reg <= 1'b0;
			dpri_reg <= 3'h0;
			dstrip_reg <= 1'b0;
			dlearn_reg <= 1'b0;
			dadd_reg <= 1'b0;
			dtag_reg <= 16'h0;
		end else begin
			throt_reg <= throt_next;
			bcap_reg <= bcap_next;
			glb_reg <= glb_next;
			mir_reg <= mir_next;
			intype_reg <= intype_next;
			egtype_reg <= egtype_next;
			pcfg_reg <= pcfg_next;
			lrn_cnt_reg <= lrn_cnt_next;
			flt_cnt_reg <= flt_cnt_next;
			tick_reg <= tick_next;
			bbytes_reg <= bbytes_next;
			prdata_reg <= prdata_next;
			dvalid_reg <= dvalid_next;
			ddest_reg <= ddest_next;
			dfilt_reg <= dfilt_next;
			dpri_reg <= dpri_next;
			dstrip_reg <= dstrip_next;
			dlearn_reg <= dlearn_next & pkt_valid;
			dadd_reg <= dadd_next & pkt_valid;
			dtag_reg <= dtag_next;
		end
	end

	assign dec_valid = dvalid_reg;
	assign dec_dest = ddest_reg;
	assign dec_filtered = dfilt_reg;
	assign dec_pri = dpri_reg;
	assign dec_strip_special = dstrip_reg;
	assign dec_learn = dlearn_reg;
	assign dec_add_special = dadd_reg;
	assign dec_special_tag = dtag_reg;
endmodule : sipct_core
`default_nettype wire

/* File: core/sipct_pkg.sv */
/*
 * Constants for the switch ingress policy and CPU tagging block.
 * Assumes an APB master and a packet-decision front end in the switch engine.
 */
`default_nettype none
package sipct_pkg;
	localparam int NPORTS = 3;
	// Register byte offsets.
	localparam logic [7:0] OFF_THROT = 8'h00;
	localparam logic [7:0] OFF_BCAP = 8'h04;
	localparam logic [7:0] OFF_GLOBAL = 8'h08;
	localparam logic [7:0] OFF_MIRROR = 8'h0C;
	localparam logic [7:0] OFF_INTYPE = 8'h10;
	localparam logic [7:0] OFF_EGTYPE = 8'h14;
	localparam logic [7:0] OFF_PORTCFG = 8'h18;
	localparam logic [7:0] OFF_LRNCNT0 = 8'h20;
	localparam logic [7:0] OFF_FLTCNT0 = 8'h30;
	// Throttle register: level in bits 7:0,15:8,23:16, enables in 26:24.
	localparam int THROT_EN_POS = 24;
	localparam logic [31:0] THROT_RESET = 32'h0000_0000;
	localparam logic [31:0] BCAP_RESET = 32'h0000_0020;
	// Global config bits.
	localparam int GLB_IGMP_EN = 0;
	localparam int GLB_REFLECT = 1;
	localparam int GLB_VLAN_EN = 2;
	localparam int GLB_MONPORT_POS = 3;
	// Mirroring config bits.
	localparam int MIR_RX_EN = 0;
	localparam int MIR_TX_EN = 1;
	localparam int MIR_FILT_EN = 2;
	localparam int MIR_RXPORTS_POS = 3;
	localparam int MIR_TXPORTS_POS = 6;
	localparam int MIR_SNIFF_POS = 9;
	// Per-port config: learn enable 2:0, tagged-only 5:3, check member 8:6, admit nonmember 11:9.
	localparam int PC_LRN_POS = 0;
	localparam int PC_TAGONLY_POS = 3;
	localparam int PC_CHKMEM_POS = 6;
	localparam int PC_NONMEM_POS = 9;
	localparam logic [1:0] PTYPE_SPECIAL = 2'h3;
	localparam logic [1:0] PTYPE_NORMAL = 2'h0;
	localparam logic [1:0] STP_FWD = 2'h0;
	localparam logic [1:0] STP_BLOCK = 2'h1;
	localparam logic [1:0] STP_LEARN = 2'h2;
	localparam logic [1:0] STP_DISABLED = 2'h3;
	localparam logic [7:0] IP_PROTO_IGMP = 8'h02;
	localparam logic [11:0] VID_RESERVED = 12'hFFF;
	localparam int BYTE_UNIT = 64;
	// Throttle interval: 1.72 ms at 200 MHz.
	localparam int CLK_MHZ = 200;
	localparam int THROT_INTERVAL_NS = 1720000;
	localparam int THROT_INTERVAL_CYC = THROT_INTERVAL_NS * CLK_MHZ / 1000;
endpackage : sipct_pkg
`default_nettype wire

/* File: dv/sipct_host_model.sv */
/*
 * Host processor model on the CPU port: forms the special tags of the frames it sends.
 * Assumes the bench calls make_tag by hierarchical reference.
 */
`default_nettype none
module sipct_host_model;
	// Longest frame the host may hand over with the four-byte special tag in front.
	localparam logic [10:0] TAGGED_LIMIT = 11'd1518;
	// Longest frame with two-kilobyte frames enabled; 11 bits cap it below 2048.
	localparam logic [10:0] JUMBO_LIMIT = 11'h7FF;
	// The host never sends a frame longer than the CPU port accepts.
	function automatic logic [10:0] clip_len(input logic [10:0] len,
		input logic two_kilobyte_frame_enable);
		logic [10:0] lim;
		lim = two_kilobyte_frame_enable ? JUMBO_LIMIT : TAGGED_LIMIT;
		return (len > lim) ? lim : len;
	endfunction : clip_len
	// A direct send to port 0 would carry VID 0 and look priority tagged,
	// so the host sets an unused VID bit instead.
	function automatic logic [15:0] make_tag(input logic [2:0] pri, input logic [11:0] vid);
		logic [11:0] v;
		v = vid;
		if (!v[3] && v[1:0] == 2'h0)
			v[2] = 1'b1;
		return {pri, 1'b0, v};
	endfunction : make_tag
endmodule : sipct_host_model
`default_nettype wire

/* File: dv/sipct_core_assertions.sv */
/*
 * Checker for sipct_core: forwarding decisions and special tag fields.
 * Assumes the single clock domain of the core; bound to every sipct_core.
 */
`default_nettype none
module sipct_core_checker #(
	parameter int THROT_CYC = 100,
	parameter int CNT_W = 16
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [1:0] pkt_src,
	input wire logic [7:0] pkt_ip_proto,
	input wire logic [15:0] pkt_tag1,
	input wire logic [2:0] pkt_class_pri,
	input wire logic lookup_hit,
	input wire logic lookup_static,
	input wire logic lookup_age,
	input wire logic lookup_pri_en,
	input wire logic [2:0] lookup_pri,
	input wire logic [5:0] port_stp_state,
	input wire logic dec_valid,
	input wire logic [2:0] dec_dest,
	input wire logic [2:0] dec_pri,
	input wire logic dec_learn,
	input wire logic dec_strip_special,
	input wire logic dec_add_special,
	input wire logic [15:0] dec_special_tag
);
	default clocking dcb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	// Decisions refer to the descriptor taken one edge earlier.
	no_echo_a: assert property (
		dec_valid && $past(pkt_ip_proto) != 8'h02 |-> !dec_dest[$past(pkt_src)])
		else $error("packet sent back out of its receiving port");
	direct_a: assert property (
		dec_valid && dec_strip_special && $past(pkt_tag1[3:0]) inside {4'h0, 4'h1, 4'h2}
		&& $past(pkt_tag1[1:0]) != $past(pkt_src) && $past(port_stp_state) == 6'h00
		|-> dec_dest[$past(pkt_tag1[1:0])])
		else $error("special tag destination port missing");
	all_ports_a: assert property (
		dec_valid && dec_strip_special && $past(pkt_tag1[3:0]) == 4'h3
		&& $past(port_stp_state) == 6'h00 |-> dec_dest == ~(3'h1 << $past(pkt_src)))
		else $error("special tag broadcast mask wrong");
	no_learn_a: assert property (
		dec_valid && dec_strip_special && !$past(pkt_tag1[3]) |-> !dec_learn)
		else $error("learning on a directed special tag");
	tag_pri_a: assert property (
		dec_valid && dec_strip_special && !$past(pkt_tag1[5]) |-> dec_pri == $past(pkt_tag1[15:13]))
		else $error("special tag priority not taken");
	tag_source_a: assert property (
		dec_valid && dec_add_special |-> dec_special_tag[1:0] == $past(pkt_src)
		&& dec_special_tag[15:13] == $past(pkt_class_pri))
		else $error("egress tag source or priority wrong");
	tag_entry_a: assert property (
		dec_valid && dec_add_special && $past(lookup_hit && lookup_static) |-> dec_special_tag[9:4]
		== {$past(lookup_pri), $past(lookup_pri_en), 1'b1, $past(lookup_age)})
		else $error("egress tag entry fields wrong");
	tag_zero_a: assert property (
		dec_valid && dec_add_special && !$past(lookup_hit && lookup_static)
		|-> dec_special_tag[9:4] == 6'h00)
		else $error("egress tag entry fields not zero");
	// Main scenarios reached.
	cover property (dec_valid && dec_add_special);
	cover property (dec_valid && dec_strip_special);
	cover property (dec_valid && dec_dest == 3'h3);
endmodule : sipct_core_checker
bind sipct_core sipct_core_checker #(.THROT_CYC(THROT_CYC), .CNT_W(CNT_W)) i_chk (.*);
`default_nettype wire

/* File: dv/testbench.sv */
/*
 * Self-checking bench for sipct_core: APB set-up, decisions, tags and counters.
 * Assumes the design package, the host model and the bound checker.
 */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int THROT = 100;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pkt_valid = 1'b0, pkt_bcast = 1'b0;
	logic pkt_flood = 1'b0, pkt_ipv4 = 1'b0, pkt_mcast = 1'b0, pkt_tagged = 1'b0;
	logic pkt_tag2_valid = 1'b0, lookup_hit = 1'b0, lookup_static = 1'b0, lookup_age = 1'b0;
	logic lookup_pri_en = 1'b0, pready, pslverr, rerr, dec_valid, dec_filtered, dec_learn;
	logic dec_strip_special, dec_add_special;
	logic [1:0] pkt_src = 2'h0;
	logic [10:0] pkt_len = 11'h040;
	logic [7:0] paddr = 8'h00, pkt_ip_proto = 8'h00, bcast_buffers_used = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rq, base;
	logic [15:0] pkt_tag1 = 16'h0, dec_special_tag;
	logic [11:0] pkt_vid2 = 12'h0;
	logic [2:0] pkt_class_pri = 3'h0, lookup_dest = 3'h0, lookup_pri = 3'h0, dec_dest, dec_pri;
	logic [2:0] vlan_members = 3'h7, learn_discard_evt = 3'h0;
	logic [5:0] port_stp_state = 6'h00;
	int fails = 0;
	int tests_run = 0;
	sipct_core #(.THROT_CYC(THROT), .CNT_W(16)) i_sipct_core (.*);
	sipct_host_model i_sipct_host_model ();
	initial forever #2.5 clock = ~clock;
	// Every comparison is counted; a mismatch is reported at once.
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic tally_and_finish();
		if (fails == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rq = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic stp(input logic [5:0] s);
		@(posedge clock);
		port_stp_state <= s;
	endtask : stp
	// One descriptor; f holds IGMP, static entry and broadcast flags.
	task automatic fire(input logic [1:0] src, input logic [15:0] tag, input logic [2:0] ldest,
		input logic [2:0] f);
		@(posedge clock);
		pkt_valid <= 1'b1;
		pkt_src <= src;
		pkt_tag1 <= tag;
		pkt_tagged <= |tag;
		lookup_dest <= ldest;
		lookup_hit <= |ldest;
		pkt_ipv4 <= f[0];
		pkt_ip_proto <= f[0] ? sipct_pkg::IP_PROTO_IGMP : 8'h06;
		pkt_mcast <= f[0] | f[2];
		lookup_static <= f[1];
		lookup_age <= f[1];
		lookup_pri_en <= f[1];
		lookup_pri <= {src, 1'b1};
		pkt_class_pri <= {1'b1, src};
		pkt_bcast <= f[2];
		pkt_flood <= f[2];
		@(posedge clock);
		pkt_valid <= 1'b0;
		#1;
	endtask : fire
	// The destination only matters for admitted packets.
	task automatic dchk(input logic [2:0] dest, input logic filt);
		chk("dec_valid", 32'(dec_valid), 32'h1);
		chk("dec_filtered", 32'(dec_filtered), 32'(filt));
		if (!filt)
			chk("dec_dest", 32'(dec_dest), 32'(dest));
	endtask : dchk
	task automatic t_regs();
		apb(1'b0, sipct_pkg::OFF_BCAP, 32'h0);
		chk("bcast_cap", rq, sipct_pkg::BCAP_RESET);
		@(posedge clock);
		learn_discard_evt <= 3'h4;
		repeat (2) @(posedge clock);
		learn_discard_evt <= 3'h0;
		apb(1'b1, 8'h28, 32'h5);
		apb(1'b0, 8'h28, 32'h0);
		chk("learn_cnt2", rq, 32'h2);
		apb(1'b0, sipct_pkg::OFF_LRNCNT0, 32'h0);
		chk("learn_cnt0", rq, 32'h0);
		apb(1'b0, 8'h3C, 32'h0);
		chk("unmapped_err", 32'(rerr), 32'h1);
	endtask : t_regs
	task automatic t_igmp();
		apb(1'b1, sipct_pkg::OFF_GLOBAL, 32'h1);
		fire(2'h1, 16'h0, 3'h4, 3'h1);
		dchk(3'h1, 1'b0);
		fire(2'h2, 16'h0005, 3'h2, 3'h1);
		dchk(3'h1, 1'b0);
		fire(2'h0, 16'h0, 3'h2, 3'h1);
		dchk(3'h0, 1'b0);
		apb(1'b1, sipct_pkg::OFF_GLOBAL, 32'h3);
		fire(2'h0, 16'h0, 3'h2, 3'h1);
		dchk(3'h1, 1'b0);
		stp(6'h0C);
		fire(2'h1, 16'h0, 3'h1, 3'h1);
		dchk(3'h0, 1'b1);
		stp(6'h00);
		apb(1'b1, sipct_pkg::OFF_GLOBAL, 32'h5);
		fire(2'h1, 16'h0FFF, 3'h1, 3'h1);
		dchk(3'h0, 1'b1);
		apb(1'b1, sipct_pkg::OFF_GLOBAL, 32'h0);
	endtask : t_igmp
	task automatic t_mirror();
		apb(1'b1, sipct_pkg::OFF_MIRROR, 32'h21);
		fire(2'h2, 16'h0, 3'h2, 3'h0);
		dchk(3'h3, 1'b0);
		apb(1'b1, sipct_pkg::OFF_MIRROR, 32'h102);
		fire(2'h1, 16'h0, 3'h4, 3'h0);
		dchk(3'h5, 1'b0);
		apb(1'b1, sipct_pkg::OFF_MIRROR, 32'h211);
		fire(2'h1, 16'h0, 3'h4, 3'h0);
		dchk(3'h4, 1'b0);
		apb(1'b1, sipct_pkg::OFF_MIRROR, 32'h0);
	endtask : t_mirror
	task automatic t_special();
		apb(1'b1, sipct_pkg::OFF_INTYPE, 32'h3);
		apb(1'b1, sipct_pkg::OFF_PORTCFG, 32'h1);
		pkt_len <= i_sipct_host_model.clip_len(11'h040, 1'b0);
		for (int d = 1; d < 4; d++) begin
			fire(2'h0, i_sipct_host_model.make_tag(3'h4, 12'(d)), 3'h0, 3'h0);
			dchk(3'(d == 3 ? 3'h6 : 3'h1 << d), 1'b0);
			chk("learn_direct", 32'(dec_learn), 32'h0);
			chk("strip", 32'(dec_strip_special), 32'h1);
			chk("pri", 32'(dec_pri), 32'h4);
		end
		stp(6'h10);
		fire(2'h0, i_sipct_host_model.make_tag(3'h0, 12'h012), 3'h0, 3'h0);
		dchk(3'h4, 1'b0);
		fire(2'h0, i_sipct_host_model.make_tag(3'h0, 12'h002), 3'h0, 3'h0);
		chk("blocked", 32'(dec_dest[2]), 32'h0);
		stp(6'h00);
		fire(2'h0, i_sipct_host_model.make_tag(3'h0, 12'h008), 3'h2, 3'h0);
		dchk(3'h2, 1'b0);
		chk("learn_lookup", 32'(dec_learn), 32'h1);
		apb(1'b1, sipct_pkg::OFF_PORTCFG, 32'h0);
		apb(1'b1, sipct_pkg::OFF_INTYPE, 32'h0);
		fire(2'h0, 16'h8002, 3'h2, 3'h0);
		chk("no_strip", 32'(dec_strip_special), 32'h0);
	endtask : t_special
	task automatic t_egress();
		apb(1'b1, sipct_pkg::OFF_EGTYPE, 32'h3);
		fire(2'h1, 16'h0, 3'h1, 3'h2);
		chk("add_tag", 32'(dec_add_special), 32'h1);
		chk("tag_static", 32'(dec_special_tag), {16'h0, 3'h5, 3'h0, 3'h3, 3'h7, 4'h1});
		fire(2'h1, 16'h0, 3'h1, 3'h0);
		chk("tag_learned", 32'(dec_special_tag), {16'h0, 3'h5, 11'h000, 2'h1});
		apb(1'b1, sipct_pkg::OFF_EGTYPE, 32'h0);
	endtask : t_egress
	// Level 1 on port 1 admits one 64-byte broadcast per interval.
	task automatic t_throttle();
		apb(1'b0, 8'h34, 32'h0);
		base = rq;
		apb(1'b1, sipct_pkg::OFF_THROT, 32'h0200_0100);
		// Start just after an interval boundary so both packets share one budget.
		while (i_sipct_core.tick_reg != 32'h0)
			@(posedge clock);
		fire(2'h1, 16'h0, 3'h0, 3'h4);
		chk("bc_first", 32'(dec_filtered), 32'h0);
		fire(2'h1, 16'h0, 3'h0, 3'h4);
		chk("bc_second", 32'(dec_filtered), 32'h1);
		apb(1'b0, 8'h34, 32'h0);
		chk("filt_cnt1", rq, base + 32'h1);
		repeat (THROT) @(posedge clock);
		fire(2'h1, 16'h0, 3'h0, 3'h4);
		chk("bc_next", 32'(dec_filtered), 32'h0);
	endtask : t_throttle
	initial begin
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		t_regs();
		t_igmp();
		t_mirror();
		t_special();
		t_egress();
		t_throttle();
		tally_and_finish();
	end
	// A hang ends the run as a failure.
	initial begin
		repeat (4000) @(posedge clock);
		fails++;
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
